// ===== rtl/aril_defines.svh
// Constants of the alarm relay and external input block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef ARIL_DEFINES_SVH
`define ARIL_DEFINES_SVH

`define ARIL_CLK_PERIOD_NS 10
`define ARIL_NUM_SRC 4
`define ARIL_VAL_W 16
// Flash half period in milliseconds, and its cycle count
`define ARIL_FLASH_HALF_MS 1000
`define ARIL_FLASH_CYCLES ((`ARIL_FLASH_HALF_MS * 1000000) / `ARIL_CLK_PERIOD_NS)
// Toggle-mode energize pulse in milliseconds, and its cycle count
`define ARIL_TOGGLE_PULSE_MS 200
`define ARIL_TOGGLE_CYCLES ((`ARIL_TOGGLE_PULSE_MS * 1000000) / `ARIL_CLK_PERIOD_NS)

`endif

// ===== rtl/aril_pkg.sv
// Types of the alarm relay and external input block.
// Assumes nothing beyond a SystemVerilog compiler.
package aril_pkg;

    typedef enum logic [2:0] {
        ARIL_DI_NONE = 3'h0,
        ARIL_DI_FORCE_ON = 3'h1,
        ARIL_DI_FORCE_OFF = 3'h2,
        ARIL_DI_ALARM = 3'h3,
        ARIL_DI_SELECTOR = 3'h4
    } aril_di_mode_t;

    typedef enum logic [1:0] {
        ARIL_SEL_AUTO = 2'h0,
        ARIL_SEL_HAND = 2'h1,
        ARIL_SEL_OFF = 2'h2
    } aril_sel_pos_t;

    typedef enum logic [1:0] {
        ARIL_RLY_NORMAL = 2'h0,
        ARIL_RLY_FLASH = 2'h1,
        ARIL_RLY_TOGGLE = 2'h2
    } aril_rly_mode_t;

endpackage : aril_pkg

// ===== rtl/aril_alarm_relay.sv
// Alarm qualification, fail-safe alarm relay driver and external input override.
// Assumes all inputs are synchronous to I_SYS_CLK and configuration is quasi-static.
`timescale 1ns/1ps
`include "aril_defines.svh"

module aril_alarm_relay #(
    parameter int unsigned FLASH_CYCLES = `ARIL_FLASH_CYCLES,
    parameter int unsigned TOGGLE_CYCLES = `ARIL_TOGGLE_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic [`ARIL_NUM_SRC-1:0][`ARIL_VAL_W-1:0] I_SRC_VALUE,
    input wire logic [`ARIL_NUM_SRC-1:0][`ARIL_VAL_W-1:0] I_SRC_SETPOINT,
    input wire logic [`ARIL_NUM_SRC-1:0] I_SRC_IS_THRESH,
    input wire logic [`ARIL_NUM_SRC-1:0] I_SRC_ABOVE,
    input wire logic [`ARIL_NUM_SRC-1:0] I_SRC_EVENT,
    input wire logic [`ARIL_NUM_SRC-1:0] I_SRC_FILTER_EN,
    input wire logic [`ARIL_NUM_SRC-1:0][15:0] I_SRC_FILTER_TICKS,
    input wire logic [`ARIL_NUM_SRC:0] I_SRC_ENABLE,
    input wire logic [`ARIL_NUM_SRC:0] I_SRC_LATCH,
    input wire logic I_ALARM_CLEAR,
    input wire logic I_CONTACT_CLOSED,
    input wire logic I_DI_ACTIVE_CLOSED,
    input wire aril_pkg::aril_di_mode_t I_DI_MODE,
    input wire aril_pkg::aril_sel_pos_t I_HAND_OFF_AUTO_SELECTOR,
    input wire logic I_CONTROL_DEMAND,
    input wire aril_pkg::aril_rly_mode_t I_RELAY_MODE,
    output logic [`ARIL_NUM_SRC:0] O_ALARM_ACTIVE,
    output logic O_ANY_ALARM,
    output logic O_HEATER_ON,
    output logic O_RELAY_ENERGIZE
);

    localparam int NS = `ARIL_NUM_SRC;
    localparam int EXT = `ARIL_NUM_SRC;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic f_contact_hit(input logic closed, input logic act_closed);
        f_contact_hit = (closed == act_closed);
    endfunction : f_contact_hit

    function automatic logic f_cross(input logic [`ARIL_VAL_W-1:0] v,
                                     input logic [`ARIL_VAL_W-1:0] sp,
                                     input logic above);
        f_cross = above ? (v > sp) : (v < sp);
    endfunction : f_cross

    logic contact_hit;
    assign contact_hit = f_contact_hit(I_CONTACT_CLOSED, I_DI_ACTIVE_CLOSED);

    // ------------------------------------------------------------
    // Alarm source qualification
    // ------------------------------------------------------------
    logic [NS:0] cond;
    logic [NS:0] pass;
    logic [NS:0] active_q;
    logic [NS:0] active_d;
    logic [NS:0] prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_src
            logic [15:0] filt_q;
            logic filt_done;
            // Condition gated by enable so no setting of a disabled source matters
            assign cond[gi] = I_SRC_ENABLE[gi] & (I_SRC_IS_THRESH[gi] ?
                f_cross(I_SRC_VALUE[gi], I_SRC_SETPOINT[gi], I_SRC_ABOVE[gi]) :
                I_SRC_EVENT[gi]);
            assign filt_done = (filt_q >= I_SRC_FILTER_TICKS[gi]);
            assign pass[gi] = cond[gi] & (~I_SRC_FILTER_EN[gi] | filt_done);

            always_ff @(posedge I_SYS_CLK) begin
                if (!I_RST_N || !cond[gi]) begin
                    filt_q <= 16'h0000;
                end else if (!filt_done) begin
                    filt_q <= filt_q + 16'h0001;
                end
            end
        end
    endgenerate

    // Contact alarm is its own source, unfiltered
    assign cond[EXT] = I_SRC_ENABLE[EXT] & (I_DI_MODE == aril_pkg::ARIL_DI_ALARM)
                       & contact_hit;
    assign pass[EXT] = cond[EXT];

    always_comb begin
        active_d = pass;
        for (int k = 0; k <= NS; k++) begin
            // Hold a latched alarm unless cleared with its cause gone; set wins
            if (I_SRC_ENABLE[k] && I_SRC_LATCH[k] && active_q[k]
                && !(I_ALARM_CLEAR && !cond[k])) begin
                active_d[k] = 1'b1;
            end
        end
        active_d = active_d & I_SRC_ENABLE;
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            active_q <= '0;
            prev_q <= '0;
        end else begin
            active_q <= active_d;
            prev_q <= active_q;
        end
    end

    assign O_ALARM_ACTIVE = active_q;
    assign O_ANY_ALARM = |active_q;

    logic new_evt;
    assign new_evt = |(active_q & ~prev_q);

    // ------------------------------------------------------------
    // Heater override
    // ------------------------------------------------------------
    logic heater_d;
    always_comb begin
        heater_d = I_CONTROL_DEMAND;
        unique case (I_DI_MODE)
            aril_pkg::ARIL_DI_FORCE_ON: if (contact_hit) heater_d = 1'b1;
            aril_pkg::ARIL_DI_FORCE_OFF: if (contact_hit) heater_d = 1'b0;
            aril_pkg::ARIL_DI_SELECTOR: begin
                unique case (I_HAND_OFF_AUTO_SELECTOR)
                    aril_pkg::ARIL_SEL_HAND: heater_d = 1'b1;
                    aril_pkg::ARIL_SEL_OFF: heater_d = 1'b0;
                    aril_pkg::ARIL_SEL_AUTO: heater_d = I_CONTROL_DEMAND;
                    default: heater_d = I_CONTROL_DEMAND;
                endcase
            end
            aril_pkg::ARIL_DI_NONE, aril_pkg::ARIL_DI_ALARM: heater_d = I_CONTROL_DEMAND;
            default: heater_d = I_CONTROL_DEMAND;
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_HEATER_ON <= 1'b0;
        end else begin
            O_HEATER_ON <= heater_d;
        end
    end

    // ------------------------------------------------------------
    // Alarm relay
    // ------------------------------------------------------------
    logic [31:0] flash_cnt_q;
    logic flash_ph_q;
    logic [31:0] pulse_q;
    logic relay_d;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || !O_ANY_ALARM || I_RELAY_MODE != aril_pkg::ARIL_RLY_FLASH) begin
            flash_cnt_q <= 32'h0;
            flash_ph_q <= 1'b0;
        end else if (flash_cnt_q == FLASH_CYCLES - 1) begin
            flash_cnt_q <= 32'h0;
            flash_ph_q <= ~flash_ph_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || !O_ANY_ALARM || I_RELAY_MODE != aril_pkg::ARIL_RLY_TOGGLE) begin
            pulse_q <= 32'h0;
        end else if (new_evt) begin
            pulse_q <= TOGGLE_CYCLES;
        end else if (pulse_q != 32'h0) begin
            pulse_q <= pulse_q - 32'h1;
        end
    end

    // Healthy keeps the relay energized in every mode, so losing power reads as an alarm
    always_comb begin
        relay_d = !O_ANY_ALARM;
        unique case (I_RELAY_MODE)
            aril_pkg::ARIL_RLY_FLASH: relay_d = !O_ANY_ALARM | flash_ph_q;
            aril_pkg::ARIL_RLY_TOGGLE: relay_d = !O_ANY_ALARM | (pulse_q != 32'h0);
            aril_pkg::ARIL_RLY_NORMAL: relay_d = !O_ANY_ALARM;
            default: relay_d = !O_ANY_ALARM;
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_RELAY_ENERGIZE <= 1'b0;
        end else begin
            O_RELAY_ENERGIZE <= relay_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    property p_none_pass;
        (I_DI_MODE == aril_pkg::ARIL_DI_NONE) |=> (O_HEATER_ON == $past(I_CONTROL_DEMAND));
    endproperty
    a_none_pass: assert property (p_none_pass) else $error("none mode altered heater");

    property p_force_on;
        (I_DI_MODE == aril_pkg::ARIL_DI_FORCE_ON && contact_hit) |=> O_HEATER_ON;
    endproperty
    a_force_on: assert property (p_force_on) else $error("force on failed");

    property p_force_off;
        (I_DI_MODE == aril_pkg::ARIL_DI_FORCE_OFF && contact_hit) |=> !O_HEATER_ON;
    endproperty
    a_force_off: assert property (p_force_off) else $error("force off failed");

    property p_ext_alarm;
        (I_DI_MODE == aril_pkg::ARIL_DI_ALARM && contact_hit && I_SRC_ENABLE[EXT])
            |=> O_ALARM_ACTIVE[EXT] && O_ANY_ALARM;
    endproperty
    a_ext_alarm: assert property (p_ext_alarm) else $error("contact alarm missing");

    sequence s_selector(aril_pkg::aril_sel_pos_t pos);
        I_DI_MODE == aril_pkg::ARIL_DI_SELECTOR && I_HAND_OFF_AUTO_SELECTOR == pos;
    endsequence

    property p_sel_hand;
        s_selector(aril_pkg::ARIL_SEL_HAND) |=> O_HEATER_ON;
    endproperty
    a_sel_hand: assert property (p_sel_hand) else $error("hand not on");

    property p_sel_off;
        s_selector(aril_pkg::ARIL_SEL_OFF) |=> !O_HEATER_ON;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("off not off");

    property p_sel_auto;
        s_selector(aril_pkg::ARIL_SEL_AUTO) |=> (O_HEATER_ON == $past(I_CONTROL_DEMAND));
    endproperty
    a_sel_auto: assert property (p_sel_auto) else $error("auto overrode demand");

    property p_normal_relay;
        (I_RELAY_MODE == aril_pkg::ARIL_RLY_NORMAL) |=> (O_RELAY_ENERGIZE == !$past(O_ANY_ALARM));
    endproperty
    a_normal_relay: assert property (p_normal_relay) else $error("normal relay wrong");

    property p_idle_energized;
        !O_ANY_ALARM |=> O_RELAY_ENERGIZE;
    endproperty
    a_idle_energized: assert property (p_idle_energized) else $error("relay off, no alarm");

    sequence s_flash_wrap;
        I_RELAY_MODE == aril_pkg::ARIL_RLY_FLASH && O_ANY_ALARM
            && flash_cnt_q == FLASH_CYCLES - 1;
    endsequence

    property p_flash_flip;
        s_flash_wrap ##1 (I_RELAY_MODE == aril_pkg::ARIL_RLY_FLASH && O_ANY_ALARM)
            |=> (O_RELAY_ENERGIZE != $past(O_RELAY_ENERGIZE));
    endproperty
    a_flash_flip: assert property (p_flash_flip) else $error("flash did not flip");

    sequence s_toggle_evt;
        I_RELAY_MODE == aril_pkg::ARIL_RLY_TOGGLE && new_evt;
    endsequence

    property p_toggle_pulse;
        s_toggle_evt ##1 (I_RELAY_MODE == aril_pkg::ARIL_RLY_TOGGLE && O_ANY_ALARM)
            |=> O_RELAY_ENERGIZE;
    endproperty
    a_toggle_pulse: assert property (p_toggle_pulse) else $error("toggle pulse missing");

    property p_disabled_quiet;
        ((~$past(I_SRC_ENABLE)) & O_ALARM_ACTIVE) == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source alarmed");

    property p_latch_hold;
        !I_ALARM_CLEAR
            |=> (($past(active_q & I_SRC_LATCH & I_SRC_ENABLE) & ~active_q) == '0);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped");

endmodule : aril_alarm_relay

// ===== sim/aril_field_partner.sv
// Field side model: external contact switch and alarm annunciator lamp.
// Assumes the bench moves the switch command clear of the clock edge.
`timescale 1ns/1ps

module aril_field_partner (
    input wire logic i_switch_closed_cmd,
    input wire logic i_relay_energize,
    output logic o_contact_closed,
    output logic o_lamp_on
);
    // Dry contact follows the lever; bounce is not modelled
    assign o_contact_closed = i_switch_closed_cmd;
    // A dropped coil lights the lamp, so a dead controller reads as alarm
    assign o_lamp_on = !i_relay_energize;
endmodule : aril_field_partner

// ===== sim/aril_alarm_relay_bench.sv
// Self-checking bench of the alarm relay and external input block.
// Assumes design, package and field partner are compiled before it.
`timescale 1ns/1ps
`include "aril_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module aril_alarm_relay_bench;
    localparam int N = `ARIL_NUM_SRC;
    // Short counts keep flash and toggle periods to a few cycles
    localparam int FC = 8;
    localparam int TC = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [N-1:0][`ARIL_VAL_W-1:0] val = '0;
    logic [N-1:0][`ARIL_VAL_W-1:0] sp = '0;
    logic [N-1:0][15:0] fticks = '0;
    logic [N-1:0] thr = '0;
    logic [N-1:0] abv = '0;
    logic [N-1:0] evt = '0;
    logic [N-1:0] fen = '0;
    logic [N:0] en = '0;
    logic [N:0] lat = '0;
    logic [N:0] alarm;
    logic clr = 1'b0;
    logic cmd = 1'b0;
    logic act_cl = 1'b0;
    logic dem = 1'b0;
    aril_pkg::aril_di_mode_t di_mode = aril_pkg::ARIL_DI_NONE;
    aril_pkg::aril_sel_pos_t sel = aril_pkg::ARIL_SEL_AUTO;
    aril_pkg::aril_rly_mode_t rmode = aril_pkg::ARIL_RLY_NORMAL;
    logic contact, any, heat, rly, lamp;
    int fails = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    aril_alarm_relay #(.FLASH_CYCLES(FC), .TOGGLE_CYCLES(TC)) DUT (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SRC_VALUE(val), .I_SRC_SETPOINT(sp),
        .I_SRC_IS_THRESH(thr), .I_SRC_ABOVE(abv), .I_SRC_EVENT(evt),
        .I_SRC_FILTER_EN(fen), .I_SRC_FILTER_TICKS(fticks), .I_SRC_ENABLE(en),
        .I_SRC_LATCH(lat), .I_ALARM_CLEAR(clr), .I_CONTACT_CLOSED(contact),
        .I_DI_ACTIVE_CLOSED(act_cl), .I_DI_MODE(di_mode), .I_HAND_OFF_AUTO_SELECTOR(sel),
        .I_CONTROL_DEMAND(dem), .I_RELAY_MODE(rmode), .O_ALARM_ACTIVE(alarm),
        .O_ANY_ALARM(any), .O_HEATER_ON(heat), .O_RELAY_ENERGIZE(rly)
    );

    aril_field_partner u_field (
        .i_switch_closed_cmd(cmd), .i_relay_energize(rly),
        .o_contact_closed(contact), .o_lamp_on(lamp)
    );

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic eh, ea, act, prv;
        int hi, fl;
        step(10);
        `CHK("relay_in_reset", 1'b0, rly)
        `CHK("lamp_in_reset", 1'b1, lamp)
        rst_n = 1'b1;
        step(2);
        `CHK("relay_idle", 1'b1, rly)
        en[N] = 1'b1;
        // Every input function against every contact, level, demand and selector
        for (int m = 0; m < 5; m++) begin
            for (int k = 0; k < 24; k++) begin
                di_mode = aril_pkg::aril_di_mode_t'(m[2:0]);
                cmd = k[0];
                act_cl = k[1];
                dem = k[2];
                sel = aril_pkg::aril_sel_pos_t'(k[4:3]);
                act = (k[0] == k[1]);
                case (m)
                    1: eh = act | k[2];
                    2: eh = !act & k[2];
                    4: eh = (k[4:3] == 2'h1) | ((k[4:3] == 2'h0) & k[2]);
                    default: eh = k[2];
                endcase
                ea = (m == 3) && act;
                step(1);
                `CHK("heater", eh, heat)
                `CHK("contact_alarm", ea, alarm[N])
            end
        end
        di_mode = aril_pkg::ARIL_DI_NONE;
        en = 5'h0f;
        evt[0] = 1'b1;
        step(1);
        `CHK("event_alarm", 1'b1, alarm[0])
        `CHK("any_alarm", 1'b1, any)
        step(1);
        `CHK("relay_alarm", 1'b0, rly)
        `CHK("lamp_alarm", 1'b1, lamp)
        evt[0] = 1'b0;
        step(1);
        `CHK("event_gone", 1'b0, alarm[0])
        step(1);
        `CHK("relay_clear", 1'b1, rly)
        // Latched source: clear is refused while the cause stands
        lat[1] = 1'b1;
        evt[1] = 1'b1;
        step(1);
        clr = 1'b1;
        step(1);
        `CHK("latch_clear_early", 1'b1, alarm[1])
        clr = 1'b0;
        evt[1] = 1'b0;
        step(3);
        `CHK("latch_hold", 1'b1, alarm[1])
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        `CHK("latch_cleared", 1'b0, alarm[1])
        evt[1] = 1'b1;
        step(1);
        evt[1] = 1'b0;
        en[1] = 1'b0;
        step(1);
        `CHK("disabled_latched", 1'b0, alarm[1])
        evt[1] = 1'b1;
        step(2);
        `CHK("disabled_event", 1'b0, alarm[1])
        evt[1] = 1'b0;
        en[1] = 1'b1;
        lat[1] = 1'b0;
        // Threshold compare is strict on both sides of the setpoint
        thr[2] = 1'b1;
        abv[2] = 1'b1;
        sp[2] = 16'h0100;
        val[2] = 16'h0100;
        step(2);
        `CHK("thresh_equal", 1'b0, alarm[2])
        val[2] = 16'h0101;
        step(1);
        `CHK("thresh_above", 1'b1, alarm[2])
        abv[2] = 1'b0;
        val[2] = 16'h00ff;
        step(1);
        `CHK("thresh_below", 1'b1, alarm[2])
        val[2] = 16'h0100;
        step(1);
        `CHK("thresh_equal_low", 1'b0, alarm[2])
        // Filter of three ticks, interrupted once to prove the restart
        fen[3] = 1'b1;
        fticks[3] = 16'h0003;
        evt[3] = 1'b1;
        step(2);
        evt[3] = 1'b0;
        step(1);
        evt[3] = 1'b1;
        step(3);
        `CHK("filter_early", 1'b0, alarm[3])
        step(1);
        `CHK("filter_done", 1'b1, alarm[3])
        evt[3] = 1'b0;
        step(1);
        `CHK("filter_drop", 1'b0, alarm[3])
        // Flash: half the cycles of whole periods are energized
        rmode = aril_pkg::ARIL_RLY_FLASH;
        evt[0] = 1'b1;
        step(3);
        hi = 0;
        fl = 0;
        prv = rly;
        repeat (4 * FC) begin
            step(1);
            hi += rly;
            fl += (rly != prv);
            prv = rly;
        end
        `CHK("flash_on_count", 2 * FC, hi)
        // One flip per half period, so a too fast toggle cannot pass
        `CHK("flash_flips", 4, fl)
        evt[0] = 1'b0;
        step(2);
        `CHK("flash_idle", 1'b1, rly)
        // Toggle: a second alarm gives one short energize pulse
        rmode = aril_pkg::ARIL_RLY_TOGGLE;
        evt[0] = 1'b1;
        step(8);
        `CHK("toggle_held", 1'b0, rly)
        evt[1] = 1'b1;
        hi = 0;
        repeat (12) begin
            step(1);
            hi += rly;
        end
        `CHK("toggle_pulse", TC, hi)
        `CHK("toggle_after", 1'b0, rly)
        evt[0] = 1'b0;
        evt[1] = 1'b0;
        step(2);
        `CHK("toggle_idle", 1'b1, rly)
        end_of_test();
    end
endmodule : aril_alarm_relay_bench
